// *** common/clock_tree_pkg.sv ***
// Shared constants and types for block sleep control and clock tree gating
package clock_tree_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_BLOCKS = 8;
  localparam int N_TREES = 6;
  localparam int N_IA_SRC = 8;
  localparam int N_GPIO_SRC = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int TREE_IDX_W = 3;

  // ----------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_BLOCK_ENABLE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TREE_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CLK_REQ = 4'h2;
  localparam logic [ADDR_W-1:0] REG_SLEEPING = 4'h3;
  localparam logic [ADDR_W-1:0] REG_TREE_ON = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SELF_GATE = 4'h5;

  // Tree control field layout: force-on bits low, force-off bits above
  localparam int FORCE_ON_LSB = 0;
  localparam int FORCE_OFF_LSB = 6;
  localparam int TREE_CTRL_W = 12;

  // Self-gating status fields
  localparam int SELF_IA_BIT = 0;
  localparam int SELF_GPIO_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [N_BLOCKS-1:0] BLOCK_ENABLE_RST = 8'h00;
  localparam logic [TREE_CTRL_W-1:0] TREE_CTRL_RST = 12'h000;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Tree numbers and the block-to-tree map
  // ----------------------------------------------------------------
  localparam logic [TREE_IDX_W-1:0] CORE_TREE = 3'h0;
  typedef logic [TREE_IDX_W-1:0] tree_idx_t;
  localparam tree_idx_t BLOCK_TREE [N_BLOCKS] = '{
    3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5
  };

  // ----------------------------------------------------------------
  // Per-block sleep state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BLK_DISABLED = 4'b0001,
    BLK_RUNNING = 4'b0010,
    BLK_PREP_SLEEP = 4'b0100,
    BLK_SLEEPING = 4'b1000
  } blk_state_t;

endpackage

// *** core/clock_gate_cell.sv ***
// Glitch-free latch-based clock gate for one master clock tree
`timescale 1ns/1ps
module clock_gate_cell (
  input wire logic clk_in,
  input wire logic enable,
  output logic gated_clk
);

  logic en_latched;

  // Enable passes only while the clock is low, so a change can never
  // chop a high phase already in progress
  always_latch begin
    if (!clk_in) begin
      en_latched <= enable;
    end
  end

  assign gated_clk = clk_in & en_latched;

endmodule // clock_gate_cell

// *** core/block_sleep_clock_ctrl.sv ***
// Block sleep state machines and master clock tree gating
//
// Overview of operation
// RULE1: Disabled block ignores sleep enable changes.
// RULE2: Enable bits clear, blocks disabled after reset.
// RULE3: Sleep request waits for idle before sleeping.
// RULE4: Sleep withdrawn before idle returns to running.
// RULE5: Sleeping block gates clocks, outputs static.
// RULE6: Wake needs clocks running, sleep enable low.
// RULE7: Clearing enable disables running block immediately.
// RULE8: Sleeping to disabled only with oscillator running.
// RULE9: Six trees: forced on, off, or dynamic.
// RULE10: Dynamic tree on when required or accessed.
// RULE11: All trees dynamic after reset.
// RULE12: Aggregator clock off only when sources quiet.
// RULE13: Software clears all pending interrupts at source.
// RULE14: Level GPIO interrupts keep clocks running.
// RULE15: GPIO clock off only when sources quiet.
// RULE16: Core tree stays on while aggregator clocked.
// RULE17: Core tree stays on while GPIO clocked.
// RULE18: Core tree follows embedded core run state.
// RULE19: Force bits: 00 dynamic, on, off.
// RULE20: Clock required high in running or preparing.
// RULE21: Trees gated by glitch-free latch cells.
`timescale 1ns/1ps
module block_sleep_clock_ctrl
  import clock_tree_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [N_BLOCKS-1:0] sleep_enable,
  input wire logic [N_BLOCKS-1:0] block_idle,
  input wire logic [N_TREES-1:0] bus_tree_access,
  input wire logic [N_IA_SRC-1:0] ia_sources,
  input wire logic [N_GPIO_SRC-1:0] gpio_sources,
  input wire logic core_clk_running,
  input wire logic system_clocks_running,
  input wire logic ring_osc_running,
  output logic [N_BLOCKS-1:0] block_clock_required,
  output logic [N_BLOCKS-1:0] block_clock_enable,
  output logic ia_clock_on,
  output logic gpio_clock_on,
  output logic [N_TREES-1:0] tree_clock_on,
  output logic [N_TREES-1:0] tree_clk
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    blk_state_t [N_BLOCKS-1:0] blk;
    logic [N_BLOCKS-1:0] enable;
    logic [TREE_CTRL_W-1:0] tree_ctrl;
    logic [N_BLOCKS-1:0] clk_req;
    logic [N_BLOCKS-1:0] clk_en;
    logic ia_on;
    logic gpio_on;
    logic [N_TREES-1:0] tree_on;
    logic [DATA_W-1:0] rdata;
  } ctrl_state_t;

  ctrl_state_t state_q;
  ctrl_state_t state_d;

  logic [N_TREES-1:0] force_on;
  logic [N_TREES-1:0] force_off;
  logic [N_TREES-1:0] tree_demand;

  assign force_on = state_q.tree_ctrl[FORCE_ON_LSB +: N_TREES];
  assign force_off = state_q.tree_ctrl[FORCE_OFF_LSB +: N_TREES];

  // ----------------------------------------------------------------
  // Dynamic demand per tree
  // ----------------------------------------------------------------
  // Tree zero has no clock-required blocks; it follows the core and
  // holds on while either self-gating unit is still clocked
  always_comb begin
    tree_demand = bus_tree_access; // [RULE10]
    tree_demand[CORE_TREE] = bus_tree_access[CORE_TREE] | core_clk_running // [RULE18]
                           | state_q.ia_on | state_q.gpio_on; // [RULE16] [RULE17]
    for (int b = 0; b < N_BLOCKS; b++) begin
      if (state_q.clk_req[b]) begin
        tree_demand[BLOCK_TREE[b]] = 1'b1; // [RULE10]
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // Sleep state machine per block
    for (int b = 0; b < N_BLOCKS; b++) begin
      case (state_q.blk[b])
        BLK_DISABLED: begin
          // Sleep enable is not looked at here at all
          if (state_q.enable[b]) begin
            state_d.blk[b] = BLK_RUNNING; // [RULE1]
          end
        end
        BLK_RUNNING: begin
          if (!state_q.enable[b]) begin
            state_d.blk[b] = BLK_DISABLED; // [RULE7]
          end else if (sleep_enable[b]) begin
            state_d.blk[b] = BLK_PREP_SLEEP; // [RULE3]
          end
        end
        BLK_PREP_SLEEP: begin
          // Withdrawal of the request wins over a coincident idle
          if (!state_q.enable[b]) begin
            state_d.blk[b] = BLK_DISABLED; // [RULE7]
          end else if (!sleep_enable[b]) begin
            state_d.blk[b] = BLK_RUNNING; // [RULE4]
          end else if (block_idle[b]) begin
            state_d.blk[b] = BLK_SLEEPING; // [RULE3]
          end
        end
        BLK_SLEEPING: begin
          // With the oscillator stopped a disable is held off, not lost
          if (!state_q.enable[b]) begin
            if (ring_osc_running) begin
              state_d.blk[b] = BLK_DISABLED; // [RULE8]
            end
          end else if (!sleep_enable[b] && system_clocks_running) begin
            state_d.blk[b] = BLK_RUNNING; // [RULE6]
          end
        end
        default: begin
          state_d.blk[b] = BLK_DISABLED;
        end
      endcase
      // Status follows the state being entered so it never lags it
      state_d.clk_req[b] = (state_d.blk[b] == BLK_RUNNING)
                         || (state_d.blk[b] == BLK_PREP_SLEEP); // [RULE20]
      // Internal clock off in sleep and disable keeps outputs frozen
      state_d.clk_en[b] = state_d.clk_req[b]; // [RULE5]
    end

    // Self-gating units: any pending source keeps their clock alive
    state_d.ia_on = |ia_sources; // [RULE12] [RULE14]
    state_d.gpio_on = |gpio_sources; // [RULE15] [RULE14]

    // Tree gating; both force bits set is treated as dynamic
    for (int t = 0; t < N_TREES; t++) begin
      if (force_on[t] && !force_off[t]) begin
        state_d.tree_on[t] = 1'b1; // [RULE19] [RULE9]
      end else if (force_off[t] && !force_on[t]) begin
        state_d.tree_on[t] = 1'b0; // [RULE19] [RULE9]
      end else begin
        state_d.tree_on[t] = tree_demand[t]; // [RULE19] [RULE10]
      end
    end

    // Register writes
    if (reg_write) begin
      case (reg_addr)
        REG_BLOCK_ENABLE: state_d.enable = reg_wdata[N_BLOCKS-1:0];
        REG_TREE_CTRL: state_d.tree_ctrl = reg_wdata[TREE_CTRL_W-1:0];
        default: begin
        end
      endcase
    end

    // Register reads; data stand for exactly one cycle
    state_d.rdata = RDATA_ZERO;
    if (reg_read) begin
      case (reg_addr)
        REG_BLOCK_ENABLE: state_d.rdata[N_BLOCKS-1:0] = state_q.enable;
        REG_TREE_CTRL: state_d.rdata[TREE_CTRL_W-1:0] = state_q.tree_ctrl;
        REG_CLK_REQ: state_d.rdata[N_BLOCKS-1:0] = state_q.clk_req;
        REG_TREE_ON: state_d.rdata[N_TREES-1:0] = state_q.tree_on;
        REG_SLEEPING: begin
          for (int b = 0; b < N_BLOCKS; b++) begin
            state_d.rdata[b] = (state_q.blk[b] == BLK_SLEEPING);
          end
        end
        REG_SELF_GATE: begin
          state_d.rdata[SELF_IA_BIT] = state_q.ia_on;
          state_d.rdata[SELF_GPIO_BIT] = state_q.gpio_on;
        end
        default: state_d.rdata = RDATA_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Trees come out of reset on so early boot code is never starved
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < N_BLOCKS; b++) begin
        state_q.blk[b] <= BLK_DISABLED; // [RULE2]
      end
      state_q.enable <= BLOCK_ENABLE_RST; // [RULE2]
      state_q.tree_ctrl <= TREE_CTRL_RST; // [RULE11]
      state_q.clk_req <= '0;
      state_q.clk_en <= '0;
      state_q.ia_on <= 1'b1;
      state_q.gpio_on <= 1'b1;
      state_q.tree_on <= '1;
      state_q.rdata <= RDATA_ZERO;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state_q.rdata;
  assign block_clock_required = state_q.clk_req;
  assign block_clock_enable = state_q.clk_en;
  assign ia_clock_on = state_q.ia_on;
  assign gpio_clock_on = state_q.gpio_on;
  assign tree_clock_on = state_q.tree_on;

  // Gated trees are clock outputs and so pass through a gate, not a flop
  genvar gt;
  generate
    for (gt = 0; gt < N_TREES; gt++) begin : g_tree
      clock_gate_cell u_gate (
        .clk_in(sys_clk),
        .enable(state_q.tree_on[gt]),
        .gated_clk(tree_clk[gt])
      ); // [RULE21]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  genvar ab;
  generate
    for (ab = 0; ab < N_BLOCKS; ab++) begin : g_chk
      disabled_hold_a: assert property ( // [RULE1]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_DISABLED) && !state_q.enable[ab]
          |=> (state_q.blk[ab] == BLK_DISABLED))
        else $error("disabled block left disabled state");
      sleep_entry_a: assert property ( // [RULE3]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_RUNNING) && state_q.enable[ab] && sleep_enable[ab]
          ##1 (state_q.enable[ab] && sleep_enable[ab] && !block_idle[ab])
          |=> (state_q.blk[ab] == BLK_PREP_SLEEP))
        else $error("block slept before idle");
      wake_abort_a: assert property ( // [RULE4]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_PREP_SLEEP) && state_q.enable[ab] && !sleep_enable[ab]
          |=> (state_q.blk[ab] == BLK_RUNNING) && state_q.clk_req[ab])
        else $error("withdrawn sleep did not return to running");
      sleep_exit_a: assert property ( // [RULE6]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_SLEEPING) && state_q.enable[ab]
          && (sleep_enable[ab] || !system_clocks_running)
          |=> (state_q.blk[ab] == BLK_SLEEPING) && !state_q.clk_en[ab])
        else $error("block woke without clocks or with sleep enable");
      fast_disable_a: assert property ( // [RULE7]
        @(posedge sys_clk) disable iff (!reset_n)
        ((state_q.blk[ab] == BLK_RUNNING) || (state_q.blk[ab] == BLK_PREP_SLEEP))
          && !state_q.enable[ab] |=> (state_q.blk[ab] == BLK_DISABLED))
        else $error("disable not taken at once");
      sleep_disable_a: assert property ( // [RULE8]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_SLEEPING) && !state_q.enable[ab] && !ring_osc_running
          |=> (state_q.blk[ab] == BLK_SLEEPING))
        else $error("sleeping block disabled with oscillator stopped");
      osc_disable_a: assert property ( // [RULE8]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_SLEEPING) && !state_q.enable[ab] && ring_osc_running
          |=> (state_q.blk[ab] == BLK_DISABLED))
        else $error("sleeping block not disabled with oscillator running");
      clk_req_a: assert property ( // [RULE20]
        @(posedge sys_clk) disable iff (!reset_n)
        state_q.clk_req[ab] == ((state_q.blk[ab] == BLK_RUNNING)
          || (state_q.blk[ab] == BLK_PREP_SLEEP)))
        else $error("clock required disagrees with state");
      sleep_idle_a: assert property ( // [RULE3]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_PREP_SLEEP) && state_q.enable[ab] && sleep_enable[ab]
          && block_idle[ab] |=> (state_q.blk[ab] == BLK_SLEEPING))
        else $error("idle block did not enter sleep");
      sleep_static_a: assert property ( // [RULE5]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_SLEEPING) |-> !state_q.clk_en[ab] && !state_q.clk_req[ab])
        else $error("sleeping block still clocked");
      sleep_wake_a: assert property ( // [RULE6]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_q.blk[ab] == BLK_SLEEPING) && state_q.enable[ab] && !sleep_enable[ab]
          && system_clocks_running |=> (state_q.blk[ab] == BLK_RUNNING))
        else $error("block did not wake with clocks running");
      blk_tree_a: assert property ( // [RULE10]
        @(posedge sys_clk) disable iff (!reset_n)
        state_q.clk_req[ab] && !force_on[BLOCK_TREE[ab]] && !force_off[BLOCK_TREE[ab]]
          |=> state_q.tree_on[BLOCK_TREE[ab]])
        else $error("dynamic tree off while a block needs it");
    end
  endgenerate

  // Every tree is watched, so a force on any of them is caught
  genvar at;
  generate
    for (at = 0; at < N_TREES; at++) begin : g_tree_chk
      force_on_a: assert property ( // [RULE19]
        @(posedge sys_clk) disable iff (!reset_n)
        force_on[at] && !force_off[at] |=> state_q.tree_on[at])
        else $error("forced-on tree is off");
      force_off_a: assert property ( // [RULE19]
        @(posedge sys_clk) disable iff (!reset_n)
        force_off[at] && !force_on[at] |=> !state_q.tree_on[at])
        else $error("forced-off tree is on");
      bus_tree_a: assert property ( // [RULE10]
        @(posedge sys_clk) disable iff (!reset_n)
        bus_tree_access[at] && !force_on[at] && !force_off[at] |=> state_q.tree_on[at])
        else $error("accessed tree left off");
    end
  endgenerate

  ia_tree_zero_a: assert property ( // [RULE16]
    @(posedge sys_clk) disable iff (!reset_n)
    state_q.ia_on && !force_on[CORE_TREE] && !force_off[CORE_TREE]
      |=> state_q.tree_on[CORE_TREE])
    else $error("core tree gated while aggregator clocked");

  gpio_tree_zero_a: assert property ( // [RULE17]
    @(posedge sys_clk) disable iff (!reset_n)
    state_q.gpio_on && !force_on[CORE_TREE] && !force_off[CORE_TREE]
      |=> state_q.tree_on[CORE_TREE])
    else $error("core tree gated while GPIO clocked");

  core_tree_on_a: assert property ( // [RULE18]
    @(posedge sys_clk) disable iff (!reset_n)
    core_clk_running && !force_on[CORE_TREE] && !force_off[CORE_TREE]
      |=> state_q.tree_on[CORE_TREE])
    else $error("core tree off while core runs");

  core_tree_off_a: assert property ( // [RULE18]
    @(posedge sys_clk) disable iff (!reset_n)
    !core_clk_running && !state_q.ia_on && !state_q.gpio_on && !bus_tree_access[CORE_TREE]
      && !force_on[CORE_TREE] && !force_off[CORE_TREE] |=> !state_q.tree_on[CORE_TREE])
    else $error("core tree on while core sleeps");

  ia_self_gate_a: assert property ( // [RULE12]
    @(posedge sys_clk) disable iff (!reset_n)
    (|ia_sources) |=> state_q.ia_on)
    else $error("aggregator clock off with source pending");

  gpio_self_gate_a: assert property ( // [RULE15]
    @(posedge sys_clk) disable iff (!reset_n)
    (|gpio_sources) |=> state_q.gpio_on)
    else $error("GPIO clock off with source pending");

endmodule // block_sleep_clock_ctrl

// *** tb/periph_model.sv ***
// Behavioural model of the peripheral blocks and interrupt sources
`timescale 1ns/1ps
module periph_model
  import clock_tree_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [N_BLOCKS-1:0] work_start,
  input wire logic [3:0] work_len,
  input wire logic [N_IA_SRC-1:0] irq_raise,
  input wire logic [N_IA_SRC-1:0] irq_clear,
  input wire logic [N_GPIO_SRC-1:0] gpio_pin,
  input wire logic edge_mode,
  output logic [N_BLOCKS-1:0] block_idle,
  output logic [N_IA_SRC-1:0] ia_sources,
  output logic [N_GPIO_SRC-1:0] gpio_sources
);
  logic [3:0] busy_q [N_BLOCKS];
  logic [N_GPIO_SRC-1:0] pin_q;

  // ------------------------------------------------------------
  // Work countdown and pending interrupts
  // ------------------------------------------------------------
  // A block stays busy until its work drains, so sleep entry can lag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < N_BLOCKS; b++) busy_q[b] <= 4'h0;
      ia_sources <= '0;
      pin_q <= '0;
    end else begin
      for (int b = 0; b < N_BLOCKS; b++) begin
        if (work_start[b]) busy_q[b] <= work_len;
        else if (busy_q[b] != 4'h0) busy_q[b] <= busy_q[b] - 4'h1;
      end
      ia_sources <= (ia_sources | irq_raise) & ~irq_clear;
      pin_q <= gpio_pin;
    end
  end

  // Idle once no work is left
  always_comb begin
    for (int b = 0; b < N_BLOCKS; b++) block_idle[b] = (busy_q[b] == 4'h0);
  end

  // Level mode holds the source while the pin is high; edge mode pulses once
  assign gpio_sources = edge_mode ? (gpio_pin & ~pin_q) : gpio_pin;
endmodule // periph_model

// *** tb/tb_block_sleep_clock_ctrl.sv ***
// Self-checking testbench for block sleep control and clock tree gating
`timescale 1ns/1ps
module tb_block_sleep_clock_ctrl;
  import clock_tree_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [N_BLOCKS-1:0] sleep_enable = '0;
  logic [N_BLOCKS-1:0] block_idle, work_start = '0, bcr, bce;
  logic [N_TREES-1:0] bus_tree_access = '0, tree_clock_on, tree_clk;
  logic [N_IA_SRC-1:0] ia_sources, irq_raise = '0, irq_clear = '0;
  logic [N_GPIO_SRC-1:0] gpio_sources, gpio_pin = '0;
  logic core_clk_running = 1'b1;
  logic system_clocks_running = 1'b1;
  logic ring_osc_running = 1'b1;
  logic edge_mode = 1'b0;
  logic [3:0] work_len = 4'h0;
  logic ia_clock_on, gpio_clock_on;
  int miscompares = 0;
  int checked = 0;
  int edges = 0;
  int edges_on = 0;
  int edge_base = 0;
  int on_base = 0;

  block_sleep_clock_ctrl block_sleep_clock_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sleep_enable(sleep_enable), .block_idle(block_idle),
    .bus_tree_access(bus_tree_access), .ia_sources(ia_sources), .gpio_sources(gpio_sources),
    .core_clk_running(core_clk_running), .system_clocks_running(system_clocks_running),
    .ring_osc_running(ring_osc_running), .block_clock_required(bcr),
    .block_clock_enable(bce), .ia_clock_on(ia_clock_on), .gpio_clock_on(gpio_clock_on),
    .tree_clock_on(tree_clock_on), .tree_clk(tree_clk));

  periph_model periph_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .work_start(work_start), .work_len(work_len), .irq_raise(irq_raise),
    .irq_clear(irq_clear), .gpio_pin(gpio_pin), .edge_mode(edge_mode),
    .block_idle(block_idle), .ia_sources(ia_sources), .gpio_sources(gpio_sources));

  // ------------------------------------------------------------
  // Clock, gated edge counter and helpers
  // ------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;

  // Counts real pulses on one gated tree; a runt pulse would show as extra
  always @(posedge tree_clk[4]) edges++;
  // Tree 2 is the one forced on; its pulses must keep coming
  always @(posedge tree_clk[2]) edges_on++;

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short long after the sequence should have ended
  initial begin
    #100000;
    miscompares++;
    close_out;
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    cyc(2);
    rd_chk(REG_BLOCK_ENABLE, 32'h0);
    rd_chk(REG_TREE_CTRL, 32'h0);
    rd_chk(4'hf, 32'h0);
    // Sleep requests to disabled blocks must be ignored
    @(posedge sys_clk) sleep_enable <= 8'hff;
    cyc(3);
    check(bcr, 32'h0);
    rd_chk(REG_SLEEPING, 32'h0);
    @(posedge sys_clk) sleep_enable <= 8'h00;
    reg_wr(REG_BLOCK_ENABLE, 32'hff);
    cyc(3);
    check(bce, 32'hff);
    rd_chk(REG_CLK_REQ, 32'hff);
    // Blocks 0..3 busy for eight cycles when asked to sleep
    @(posedge sys_clk) begin
      work_len <= 4'h8;
      work_start <= 8'h0f;
    end
    @(posedge sys_clk) begin
      work_start <= 8'h00;
      sleep_enable <= 8'h0f;
    end
    cyc(3);
    check(bcr, 32'hff);
    rd_chk(REG_SLEEPING, 32'h0);
    // Block 1 is woken before it ever idles
    @(posedge sys_clk) sleep_enable <= 8'h0d;
    cyc(12);
    check(bcr, 32'hf2);
    check(bce, 32'hf2);
    rd_chk(REG_SLEEPING, 32'h0d);
    // Wake withheld while system clocks are stopped; busy input ignored
    @(posedge sys_clk) begin
      system_clocks_running <= 1'b0;
      work_start <= 8'h01;
    end
    @(posedge sys_clk) begin
      work_start <= 8'h00;
      sleep_enable <= 8'h0c;
    end
    cyc(3);
    check(bcr, 32'hf2);
    rd_chk(REG_SLEEPING, 32'h0d);
    @(posedge sys_clk) system_clocks_running <= 1'b1;
    cyc(3);
    check(bcr, 32'hf3);
    // Disable block 4 mid preparation and block 2 while asleep
    @(posedge sys_clk) work_start <= 8'h10;
    @(posedge sys_clk) begin
      work_start <= 8'h00;
      sleep_enable <= 8'h1c;
      ring_osc_running <= 1'b0;
    end
    reg_wr(REG_BLOCK_ENABLE, 32'heb);
    cyc(2);
    check(bcr, 32'he3);
    rd_chk(REG_SLEEPING, 32'h0c);
    @(posedge sys_clk) ring_osc_running <= 1'b1;
    cyc(3);
    rd_chk(REG_SLEEPING, 32'h08);
    // Dynamic tree gating from bus access, one tree at a time
    reg_wr(REG_BLOCK_ENABLE, 32'h0);
    @(posedge sys_clk) begin
      sleep_enable <= 8'h00;
      core_clk_running <= 1'b0;
    end
    cyc(4);
    check(tree_clock_on, 32'h0);
    for (int t = 0; t < N_TREES; t++) begin
      @(posedge sys_clk) bus_tree_access <= 6'h01 << t;
      cyc(2);
      check(tree_clock_on, 32'h1 << t);
    end
    @(posedge sys_clk) bus_tree_access <= 6'h00;
    reg_wr(REG_BLOCK_ENABLE, 32'h40);
    cyc(3);
    check(tree_clock_on, 32'h10);
    edge_base = edges;
    cyc(10);
    check(edges - edge_base, 10);
    // Force on tree 2, force off tree 4, both bits on tree 5
    reg_wr(REG_TREE_CTRL, 32'hc24);
    cyc(3);
    check(tree_clock_on, 32'h04);
    rd_chk(REG_TREE_CTRL, 32'hc24);
    edge_base = edges;
    on_base = edges_on;
    cyc(10);
    check(edges - edge_base, 0);
    check(edges_on - on_base, 10);
    reg_wr(REG_TREE_CTRL, 32'h0);
    // Aggregator clock held by a pending source until cleared
    @(posedge sys_clk) irq_raise <= 8'h08;
    @(posedge sys_clk) irq_raise <= 8'h00;
    cyc(8);
    check(ia_clock_on, 32'h1);
    check(tree_clock_on, 32'h11);
    @(posedge sys_clk) irq_clear <= 8'h08;
    @(posedge sys_clk) irq_clear <= 8'h00;
    cyc(3);
    check(ia_clock_on, 32'h0);
    check(tree_clock_on, 32'h10);
    // Level GPIO source holds its clock; edge mode lets it stop
    @(posedge sys_clk) gpio_pin <= 8'h01;
    cyc(5);
    check(gpio_clock_on, 32'h1);
    check(tree_clock_on, 32'h11);
    @(posedge sys_clk) edge_mode <= 1'b1;
    cyc(3);
    check(gpio_clock_on, 32'h0);
    check(tree_clock_on, 32'h10);
    @(posedge sys_clk) core_clk_running <= 1'b1;
    cyc(3);
    check(tree_clock_on, 32'h11);
    rd_chk(REG_SELF_GATE, 32'h0);
    rd_chk(REG_TREE_ON, 32'h11);
    // Mid-run reset drops a force and all enables again
    reg_wr(REG_TREE_CTRL, 32'h001);
    @(posedge sys_clk) reset_n <= 1'b0;
    cyc(2);
    check(bcr, 32'h0);
    @(posedge sys_clk) reset_n <= 1'b1;
    cyc(2);
    rd_chk(REG_TREE_CTRL, 32'h0);
    rd_chk(REG_BLOCK_ENABLE, 32'h0);
    close_out;
  end
endmodule // tb_block_sleep_clock_ctrl
